/* logic/ctpwm_map.svh */
// Register offsets, field positions and reset values of the PWM timer.
`ifndef CTPWM_MAP_SVH
`define CTPWM_MAP_SVH

`define CTPWM_NCH         2
`define CTPWM_CHW         1
`define CTPWM_AW          8

`define CTPWM_OFS_SC      8'h00
`define CTPWM_OFS_CNTH    8'h04
`define CTPWM_OFS_CNTL    8'h08
`define CTPWM_OFS_MODH    8'h0C
`define CTPWM_OFS_MODL    8'h10
`define CTPWM_OFS_CH0     8'h14
`define CTPWM_CH_STRIDE   8'h0C
`define CTPWM_CH_VH       8'h04
`define CTPWM_CH_VL       8'h08

`define CTPWM_B_FLAG      7
`define CTPWM_B_IE        6
`define CTPWM_B_CENTER_ALIGN_SELECT     5
`define CTPWM_B_RUN       3
`define CTPWM_B_MSB       5
`define CTPWM_B_MSA       4
`define CTPWM_B_ELSB      3
`define CTPWM_B_ELSA      2

`define CTPWM_RST_BYTE    8'h00
`define CTPWM_RST_WORD    16'h0000
`define CTPWM_CNT_TOP     16'hFFFF

`endif

/* logic/ctpwm_pkg.sv */
// Types and helpers shared by the PWM timer modules.
package ctpwm_pkg;
  `include "ctpwm_map.svh"

  typedef enum logic [1:0] {
    MODE_CAPTURE, MODE_COMPARE, MODE_EDGE_PWM, MODE_CENTER_PWM
  } ctpwm_mode_t;

  typedef enum logic [3:0] {
    SEL_NONE, SEL_SC, SEL_CNTH, SEL_CNTL, SEL_MODH, SEL_MODL,
    SEL_CSC, SEL_CVH, SEL_CVL
  } ctpwm_sel_t;

  typedef struct packed {
    logic [15:0] val;
    logic [7:0]  bhi;
    logic [7:0]  blo;
    logic        shi;
    logic        slo;
    logic        ie;
    logic [1:0]  ms;
    logic [1:0]  els;
    logic        s1;
    logic        s2;
    logic        s3;
    logic        out;
  } ctpwm_ch_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic        up;
    logic [15:0] modv;
    logic [7:0]  mhi;
    logic [7:0]  mlo;
    logic        mshi;
    logic        mslo;
    logic        overflow_interrupt_enable;
    logic        center_align_select;
    logic        run;
    logic [2:0]  ps;
    logic [6:0]  div;
    logic [15:0] lat;
    logic        latched;
    logic        lat_hi;
    logic        lat_lo;
    logic        ack;
    logic        err;
    logic [7:0]  rdata;
    ctpwm_ch_t [`CTPWM_NCH-1:0] ch;
  } ctpwm_st_t;

  typedef struct packed {
    logic flag;
    logic arm;
  } ctpwm_flg_t;

  function automatic logic [7:0] ctpwm_byte(logic [15:0] v, logic hi);
    return hi ? v[15:8] : v[7:0];
  endfunction

  function automatic logic [6:0] ctpwm_div_mask(logic [2:0] ps);
    return 7'((8'h01 << ps) - 8'h01);
  endfunction

  function automatic logic [7:0] ctpwm_ch_base(int n);
    return 8'(`CTPWM_OFS_CH0 + n * `CTPWM_CH_STRIDE);
  endfunction
endpackage

/* logic/ctpwm_flag_if.sv */
// Carrier between the timer core and one two-step clearable flag.
`timescale 1ns/1ps
interface ctpwm_flag_if;
  logic set;
  logic rd;
  logic wr;
  logic wbit;
  logic flag;
  modport owner (output set, output rd, output wr, output wbit,
                 input flag);
  modport unit  (input set, input rd, input wr, input wbit,
                 output flag);
endinterface // ctpwm_flag_if

/* logic/ctpwm_flag.sv */
// One event flag with its read-then-write-zero clear sequence.
`timescale 1ns/1ps
module ctpwm_flag
  import ctpwm_pkg::*;
(
  input  wire logic   pclk,
  input  wire logic   presetn,
  ctpwm_flag_if.unit  fi
);
  ctpwm_flg_t q;
  ctpwm_flg_t d;

  always_comb begin
    d = q;
    if (fi.wr) begin
      if (q.arm && !fi.wbit) begin
        d.flag = 1'b0;
      end
      d.arm = 1'b0;
    end else if (fi.rd && q.flag) begin
      d.arm = 1'b1;
    end
    // A new event cancels a pending clear, so it is never lost.
    if (fi.set) begin
      d.flag = 1'b1;
      d.arm  = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign fi.flag = q.flag;
endmodule // ctpwm_flag

/* logic/ctpwm_top.sv */
// PWM timer with up or up/down counter, channels and APB registers.
`timescale 1ns/1ps
module ctpwm_top
  import ctpwm_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`CTPWM_AW-1:0]   paddr,
  input  wire logic [31:0]            pwdata,
  output wire logic [31:0]            prdata,
  output wire logic                   pready,
  output wire logic                   pslverr,
  input  wire logic [`CTPWM_NCH-1:0]  chan_pin_level,
  output wire logic [`CTPWM_NCH-1:0]  chan_pin_drive,
  output wire logic [`CTPWM_NCH-1:0]  chan_pin_oe,
  output wire logic                   ovf_irq,
  output wire logic [`CTPWM_NCH-1:0]  chan_irq
);
  ctpwm_st_t                q;
  ctpwm_st_t                d;
  ctpwm_sel_t               sel;
  logic [`CTPWM_CHW-1:0]    chi;
  logic                     acc;
  logic                     rd_take;
  logic                     wr_done;
  logic                     tick;
  logic [15:0]              term;
  logic                     rev;
  logic                     wrap;
  logic                     bound;
  logic [7:0]               wb;
  logic [15:0]              cnt_view;
  logic                     ovf_flag;
  logic [`CTPWM_NCH-1:0]    ch_flag;
  logic [`CTPWM_NCH-1:0]    ch_set;
  logic [`CTPWM_NCH-1:0]    ch_rd;
  logic [`CTPWM_NCH-1:0]    ch_wr;
  ctpwm_mode_t              mode [`CTPWM_NCH];
  logic                     edge_hit;
  logic                     match;
  logic                     vok;
  logic                     lvl;
  logic                     nh;
  logic                     nl;

  ctpwm_flag_if ovf_if ();
  ctpwm_flag_if ch_if [`CTPWM_NCH] ();

  // Address decode; only the low byte lane carries data.
  always_comb begin
    sel = SEL_NONE;
    chi = '0;
    if (paddr == `CTPWM_OFS_SC) begin
      sel = SEL_SC;
    end else if (paddr == `CTPWM_OFS_CNTH) begin
      sel = SEL_CNTH;
    end else if (paddr == `CTPWM_OFS_CNTL) begin
      sel = SEL_CNTL;
    end else if (paddr == `CTPWM_OFS_MODH) begin
      sel = SEL_MODH;
    end else if (paddr == `CTPWM_OFS_MODL) begin
      sel = SEL_MODL;
    end else begin
      for (int n = 0; n < `CTPWM_NCH; n++) begin
        if (paddr == ctpwm_ch_base(n)) begin
          sel = SEL_CSC;
          chi = `CTPWM_CHW'(n);
        end else if (paddr == 8'(ctpwm_ch_base(n) + `CTPWM_CH_VH)) begin
          sel = SEL_CVH;
          chi = `CTPWM_CHW'(n);
        end else if (paddr == 8'(ctpwm_ch_base(n) + `CTPWM_CH_VL)) begin
          sel = SEL_CVL;
          chi = `CTPWM_CHW'(n);
        end
      end
    end
  end

  always_comb begin
    d = q;
    // One wait state: read data and read side effects are taken on the
    // first access edge, writes on the completing edge.
    acc = psel && penable;
    rd_take = acc && !q.ack && !pwrite;
    wr_done = acc && q.ack && pwrite;
    wb = pwdata[7:0];
    tick = q.run && (q.div == ctpwm_div_mask(q.ps));
    term = (q.modv == `CTPWM_RST_WORD) ? `CTPWM_CNT_TOP : q.modv;
    rev = tick && q.center_align_select && q.up && (q.cnt == q.modv);
    wrap = tick && !q.center_align_select && (q.cnt == term);
    // A stopped counter has no periods, so buffers load at once.
    bound = !q.run || rev || wrap;
    cnt_view = q.latched ? q.lat : q.cnt;
    ch_set = '0;
    ch_rd = '0;
    ch_wr = '0;
    edge_hit = 1'b0;
    match = 1'b0;
    vok = 1'b0;
    lvl = 1'b0;
    nh = 1'b0;
    nl = 1'b0;

    // Prescaler gives the timer clock as a one-cycle enable.
    d.div = (!q.run || tick) ? 7'h00 : 7'(q.div + 7'h01);

    if (tick) begin
      if (q.center_align_select) begin
        if (q.up) begin
          // A zero modulus never turns the count; software avoids it.
          if (q.cnt == q.modv && q.modv != `CTPWM_RST_WORD) begin
            d.up  = 1'b0;
            d.cnt = q.cnt - 16'h0001;
          end else begin
            d.cnt = q.cnt + 16'h0001;
          end
        end else if (q.cnt == `CTPWM_RST_WORD) begin
          d.up  = 1'b1;
          d.cnt = q.cnt + 16'h0001;
        end else begin
          d.cnt = q.cnt - 16'h0001;
        end
      end else begin
        d.up  = 1'b1;
        d.cnt = (q.cnt == term) ? `CTPWM_RST_WORD
                                : q.cnt + 16'h0001;
      end
    end

    if (q.mshi && q.mslo && bound) begin
      d.modv = {q.mhi, q.mlo};
      d.mshi = 1'b0;
      d.mslo = 1'b0;
    end

    for (int n = 0; n < `CTPWM_NCH; n++) begin
      if (q.center_align_select) begin
        mode[n] = MODE_CENTER_PWM;
      end else if (q.ch[n].ms[1]) begin
        mode[n] = MODE_EDGE_PWM;
      end else if (q.ch[n].ms[0]) begin
        mode[n] = MODE_COMPARE;
      end else begin
        mode[n] = MODE_CAPTURE;
      end
      d.ch[n].s1 = chan_pin_level[n];
      d.ch[n].s2 = q.ch[n].s1;
      d.ch[n].s3 = q.ch[n].s2;
      case (q.ch[n].els)
        2'b01:   edge_hit = q.ch[n].s2 && !q.ch[n].s3;
        2'b10:   edge_hit = !q.ch[n].s2 && q.ch[n].s3;
        2'b11:   edge_hit = q.ch[n].s2 != q.ch[n].s3;
        default: edge_hit = 1'b0;
      endcase
      match = tick && (q.cnt == q.ch[n].val);
      if (q.ch[n].shi && q.ch[n].slo) begin
        if (mode[n] == MODE_COMPARE || mode[n] == MODE_CAPTURE ||
            bound) begin
          d.ch[n].val = {q.ch[n].bhi, q.ch[n].blo};
          d.ch[n].shi = 1'b0;
          d.ch[n].slo = 1'b0;
        end
      end
      vok = q.ch[n].val != `CTPWM_RST_WORD && !q.ch[n].val[15];
      case (mode[n])
        MODE_CAPTURE: begin
          d.ch[n].out = 1'b0;
          if (edge_hit) begin
            d.ch[n].val = q.cnt;
            ch_set[n]   = 1'b1;
          end
        end
        MODE_COMPARE: begin
          ch_set[n] = match;
          if (match) begin
            case (q.ch[n].els)
              2'b01:   d.ch[n].out = !q.ch[n].out;
              2'b10:   d.ch[n].out = 1'b0;
              2'b11:   d.ch[n].out = 1'b1;
              default: d.ch[n].out = q.ch[n].out;
            endcase
          end
        end
        MODE_EDGE_PWM: begin
          ch_set[n] = match;
          lvl = (q.ch[n].val != `CTPWM_RST_WORD) && (q.cnt < q.ch[n].val);
          d.ch[n].out = lvl ^ q.ch[n].els[0];
        end
        default: begin
          // Active from the down-count match through zero to the up-count
          // match: 2 x value timer clocks, all of it at counts at or below the value.
          ch_set[n] = match;
          lvl = vok && (q.up ? q.cnt < q.ch[n].val
                             : q.cnt <= q.ch[n].val);
          d.ch[n].out = lvl ^ q.ch[n].els[0];
        end
      endcase
    end

    if (rd_take) begin
      if (sel == SEL_CNTH || sel == SEL_CNTL) begin
        nh = q.lat_hi || sel == SEL_CNTH;
        nl = q.lat_lo || sel == SEL_CNTL;
        if (!q.latched) begin
          d.lat = q.cnt;
        end
        d.latched = !(nh && nl);
        d.lat_hi  = nh && !nl;
        d.lat_lo  = nl && !nh;
      end
      ch_rd[chi] = sel == SEL_CSC;
    end

    if (acc && !q.ack) begin
      d.ack = 1'b1;
      d.err = sel == SEL_NONE;
      case (sel)
        SEL_SC:   d.rdata = {ovf_flag, q.overflow_interrupt_enable, q.center_align_select, 1'b0, q.run, q.ps};
        SEL_CNTH: d.rdata = ctpwm_byte(cnt_view, 1'b1);
        SEL_CNTL: d.rdata = ctpwm_byte(cnt_view, 1'b0);
        SEL_MODH: d.rdata = ctpwm_byte(q.modv, 1'b1);
        SEL_MODL: d.rdata = ctpwm_byte(q.modv, 1'b0);
        SEL_CSC:  d.rdata = {ch_flag[chi], q.ch[chi].ie, q.ch[chi].ms,
                             q.ch[chi].els, 2'b00};
        SEL_CVH:  d.rdata = ctpwm_byte(q.ch[chi].val, 1'b1);
        SEL_CVL:  d.rdata = ctpwm_byte(q.ch[chi].val, 1'b0);
        default:  d.rdata = `CTPWM_RST_BYTE;
      endcase
    end else if (acc) begin
      d.ack = 1'b0;
    end

    if (wr_done) begin
      case (sel)
        SEL_SC: begin
          d.overflow_interrupt_enable  = wb[`CTPWM_B_IE];
          d.center_align_select = wb[`CTPWM_B_CENTER_ALIGN_SELECT];
          d.run   = wb[`CTPWM_B_RUN];
          d.ps    = wb[2:0];
          d.mshi  = 1'b0;
          d.mslo  = 1'b0;
        end
        SEL_CNTH, SEL_CNTL: begin
          d.cnt     = `CTPWM_RST_WORD;
          d.up      = 1'b1;
          d.div     = 7'h00;
          d.latched = 1'b0;
          d.lat_hi  = 1'b0;
          d.lat_lo  = 1'b0;
        end
        SEL_MODH: begin
          d.mhi  = wb;
          d.mshi = 1'b1;
        end
        SEL_MODL: begin
          d.mlo  = wb;
          d.mslo = 1'b1;
        end
        SEL_CSC: begin
          ch_wr[chi]     = 1'b1;
          d.ch[chi].ie   = wb[`CTPWM_B_IE];
          d.ch[chi].ms   = wb[`CTPWM_B_MSB:`CTPWM_B_MSA];
          d.ch[chi].els  = wb[`CTPWM_B_ELSB:`CTPWM_B_ELSA];
          d.ch[chi].shi  = 1'b0;
          d.ch[chi].slo  = 1'b0;
        end
        SEL_CVH: begin
          d.ch[chi].bhi = wb;
          d.ch[chi].shi = 1'b1;
        end
        SEL_CVL: begin
          d.ch[chi].blo = wb;
          d.ch[chi].slo = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q    <= '0;
      q.up <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Overflow flag and its two-step clear.
  assign ovf_if.set  = rev || wrap;
  assign ovf_if.rd   = rd_take && sel == SEL_SC;
  assign ovf_if.wr   = wr_done && sel == SEL_SC;
  assign ovf_if.wbit = wb[`CTPWM_B_FLAG];
  assign ovf_flag    = ovf_if.flag;

  ctpwm_flag u_ovf_flag (
    .pclk    (pclk),
    .presetn (presetn),
    .fi      (ovf_if)
  );

  for (genvar g = 0; g < `CTPWM_NCH; g++) begin : g_ch
    assign ch_if[g].set  = ch_set[g];
    assign ch_if[g].rd   = ch_rd[g];
    assign ch_if[g].wr   = ch_wr[g];
    assign ch_if[g].wbit = wb[`CTPWM_B_FLAG];
    assign ch_flag[g]    = ch_if[g].flag;

    ctpwm_flag u_ch_flag (
      .pclk    (pclk),
      .presetn (presetn),
      .fi      (ch_if[g])
    );

    assign chan_pin_drive[g] = q.ch[g].out;
    // Capture channels and cleared edge selects leave the pin alone.
    assign chan_pin_oe[g] = (q.center_align_select || q.ch[g].ms != 2'b00) &&
                            q.ch[g].els != 2'b00;
    assign chan_irq[g] = ch_flag[g] && q.ch[g].ie;
  end

  assign ovf_irq = ovf_flag && q.overflow_interrupt_enable;
  assign prdata  = {24'h000000, q.rdata};
  assign pready  = q.ack;
  assign pslverr = q.ack && q.err;
endmodule // ctpwm_top

/* tb/ctpwm_props.sv */
// Port-level assertions for the PWM timer.
`timescale 1ns/1ps
`include "ctpwm_map.svh"
module ctpwm_props
  import ctpwm_pkg::*;
(
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [`CTPWM_AW-1:0]  paddr,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic [`CTPWM_NCH-1:0] chan_pin_oe,
  input wire logic                  ovf_irq,
  input wire logic [`CTPWM_NCH-1:0] chan_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  logic wdone;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= 8'h28);
  assign wdone = psel && penable && pready && pwrite;
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_decode: assert property (psel && penable && pready |->
    pslverr == !mapped) else $error("bad decode");
  a_rdata_narrow: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_reset_quiet: assert property ($rose(presetn) |->
    !ovf_irq && chan_irq == 2'h0 && chan_pin_oe == 2'h0)
    else $error("outputs active after reset");
  a_ovf_fall_write: assert property ($fell(ovf_irq) |->
    $past(wdone && paddr == 8'h00)) else $error("overflow irq dropped");
  a_ch1_fall_write: assert property ($fell(chan_irq[1]) |->
    $past(wdone && paddr == 8'h20)) else $error("channel irq dropped");
  a_ch0_irq_hold: assert property (chan_irq[0] &&
    !(psel && pwrite && paddr == 8'h14) |=> chan_irq[0])
    else $error("channel irq not level");
  a_oe_by_write: assert property ($changed(chan_pin_oe) |->
    $past(wdone)) else $error("enable moved alone");
endmodule // ctpwm_props

/* tb/ctpwm_top_test.sv */
// Self-checking bench for the PWM timer through its APB registers.
`timescale 1ns/1ps
`include "ctpwm_map.svh"
module ctpwm_top_test
  import ctpwm_pkg::*;
;
  logic                  pclk;
  logic                  presetn;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [`CTPWM_AW-1:0]  paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  last_err;
  logic [`CTPWM_NCH-1:0] chan_pin_level;
  logic [`CTPWM_NCH-1:0] chan_pin_drive;
  logic [`CTPWM_NCH-1:0] chan_pin_oe;
  logic                  ovf_irq;
  logic [`CTPWM_NCH-1:0] chan_irq;
  int                    error_cnt = 0;
  int                    total_checks = 0;
  logic [7:0]  rst_a [7] = '{8'h00, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
  logic [7:0]  pw_sc [5] = '{8'h48, 8'h48, 8'h48, 8'h48, 8'h44};
  logic [15:0] pw_v  [5] = '{16'h0003, 16'h0000, 16'h8003, 16'h0009, 16'h0003};
  int          pw_hi [5] = '{12, 0, 0, 32, 20};

  ctpwm_top i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chan_pin_level(chan_pin_level),
    .chan_pin_drive(chan_pin_drive), .chan_pin_oe(chan_pin_oe),
    .ovf_irq(ovf_irq), .chan_irq(chan_irq)
  );

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic fail(input string m);
    error_cnt++;
    $display("mismatch at %0t: %s", $time, m);
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) fail($sformatf("byte %h want %h", got, exp));
  endtask

  task automatic cmp1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) fail($sformatf("bit %b want %b", got, exp));
  endtask

  task automatic cmpn(input int got, input int exp);
    total_checks++;
    if (got != exp) fail($sformatf("high count %0d want %0d", got, exp));
  endtask

  // Every transfer ends one idle cycle after release, so the next setup
  // never assigns a strobe in the same time step as the release.
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees ready.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata[7:0];
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    apb(1'b0, a, 8'h00, r);
    cmp8(r, e);
  endtask

  task automatic clr(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] r;
    apb(1'b0, a, 8'h00, r);
    wr(a, v);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // A window of whole periods makes the count independent of phase.
  task automatic hicnt(input int n, output int hi);
    hi = 0;
    repeat (n) begin
      @(posedge pclk);
      if (chan_pin_drive[0] === 1'b1) hi++;
    end
  endtask

  initial begin
    int hi;
    logic [7:0] r;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    chan_pin_level = 2'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rst_a[i]) rdc(rst_a[i], 8'h00);
    apb(1'b0, 8'h2C, 8'h00, r);
    cmp1(last_err, 1'b1);
    cmp8(r, 8'h00);
    wr(8'h30, 8'hFF);
    cmp1(last_err, 1'b1);
    wr(`CTPWM_OFS_SC, 8'h20);
    wr(`CTPWM_OFS_MODH, 8'h00);
    wr(`CTPWM_OFS_MODL, 8'h08);
    wr(`CTPWM_OFS_SC, 8'h28);
    for (int i = 0; i < 5; i++) begin
      wr(8'h14, pw_sc[i]);
      wr(8'h18, pw_v[i][15:8]);
      wr(8'h1C, pw_v[i][7:0]);
      tick(40);
      hicnt(32, hi);
      cmpn(hi, pw_hi[i]);
    end
    cmp1(chan_pin_oe[0], 1'b1);
    cmp1(chan_irq[0], 1'b1);
    wr(`CTPWM_OFS_SC, 8'h68);
    tick(20);
    cmp1(ovf_irq, 1'b1);
    rdc(`CTPWM_OFS_SC, 8'hE8);
    tick(20);
    wr(`CTPWM_OFS_SC, 8'h68);
    rdc(`CTPWM_OFS_SC, 8'hE8);
    tick(20);
    wr(`CTPWM_OFS_SC, 8'h60);
    rdc(`CTPWM_OFS_SC, 8'hE0);
    wr(`CTPWM_OFS_SC, 8'h60);
    rdc(`CTPWM_OFS_SC, 8'h60);
    cmp1(ovf_irq, 1'b0);
    wr(`CTPWM_OFS_MODL, 8'h33);
    wr(`CTPWM_OFS_SC, 8'h60);
    wr(`CTPWM_OFS_MODH, 8'h00);
    rdc(`CTPWM_OFS_MODL, 8'h08);
    wr(`CTPWM_OFS_MODL, 8'h33);
    rdc(`CTPWM_OFS_MODL, 8'h33);
    wr(8'h1C, 8'h55);
    wr(8'h14, 8'h04);
    cmp1(chan_irq[0], 1'b0);
    wr(8'h18, 8'h00);
    rdc(8'h1C, 8'h03);
    wr(8'h1C, 8'h55);
    rdc(8'h1C, 8'h55);
    wr(`CTPWM_OFS_CNTL, 8'h77);
    rdc(`CTPWM_OFS_CNTH, 8'h00);
    rdc(`CTPWM_OFS_CNTL, 8'h00);
    wr(`CTPWM_OFS_SC, 8'h08);
    tick(60);
    rdc(`CTPWM_OFS_SC, 8'h88);
    // The count runs on, so a second low read only agrees if it is held.
    apb(1'b0, `CTPWM_OFS_CNTL, 8'h00, r);
    tick(7);
    rdc(`CTPWM_OFS_CNTL, r);
    rdc(`CTPWM_OFS_CNTH, 8'h00);
    wr(8'h14, 8'h28);
    wr(8'h18, 8'h00);
    wr(8'h1C, 8'h10);
    tick(60);
    hicnt(52, hi);
    cmpn(hi, 16);
    wr(8'h20, 8'h5C);
    wr(8'h24, 8'h00);
    wr(8'h28, 8'h05);
    rdc(8'h28, 8'h05);
    // Drop the flag left by the earlier center-mode matches.
    clr(8'h20, 8'h5C);
    tick(60);
    rdc(8'h20, 8'hDC);
    cmp1(chan_pin_drive[1], 1'b1);
    cmp1(chan_irq[1], 1'b1);
    wr(`CTPWM_OFS_SC, 8'h00);
    clr(8'h20, 8'h5C);
    rdc(8'h20, 8'h5C);
    cmp1(chan_irq[1], 1'b0);
    for (int e = 0; e < 4; e++) begin
      clr(8'h20, 8'(e << 2));
      chan_pin_level[1] <= 1'b1;
      tick(6);
      rdc(8'h20, 8'(e << 2) | (e[0] ? 8'h80 : 8'h00));
      clr(8'h20, 8'(e << 2));
      chan_pin_level[1] <= 1'b0;
      tick(6);
      rdc(8'h20, 8'(e << 2) | (e[1] ? 8'h80 : 8'h00));
    end
    stop_test();
  end

  // The sequence needs about a thousand cycles; this bound is far beyond it.
  initial begin
    #100000;
    fail("watchdog expired");
    stop_test();
  end
endmodule // ctpwm_top_test

bind ctpwm_top ctpwm_props i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .chan_pin_oe(chan_pin_oe), .ovf_irq(ovf_irq),
  .chan_irq(chan_irq)
);
